// ==== rtl/hrs_pkg.sv ====
// Constants, register map and bus carrier for the run/stop and status block.
// Assumes one 100 MHz clock shared by the bus master and the block.
package hrs_pkg;

    // ************************************************************
    // Bus carrier
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } hrs_bus_req_s;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFF_RUN_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CONTROLLER_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int RUN_STOP_BIT = 0;
    localparam int SERR_ENABLE_BIT = 3;
    localparam int HALTED_BIT = 0;
    localparam int HOST_ERR_BIT = 2;
    localparam int EVENT_IRQ_BIT = 3;
    localparam int PORT_CHANGE_BIT = 4;
    localparam int IRQ_W = 4;
    localparam int IRQ_HALT_BIT = 0;
    localparam int IRQ_HOST_ERR_BIT = 1;
    localparam int IRQ_EVENT_BIT = 2;
    localparam int IRQ_PORT_BIT = 3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [DATA_W-1:0] CONTROLLER_STATUS_RESET = 32'h0000_0001;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALT_LIMIT_MS = 16;
    localparam int HALT_LIMIT_CYCLES = (HALT_LIMIT_MS * 1000000) / CLK_PERIOD_NS;

    // ************************************************************
    // Halt sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        HRS_RUNNING = 3'b001,
        HRS_DRAINING = 3'b010,
        HRS_HALTED = 3'b100
    } hrs_state_e;

endpackage

// ==== rtl/hrs_core.sv ====
// Run/stop halt sequencer and low controller status bits with interrupt logic.
// Assumes the execution engine, interrupters and root hub ports share clk.
// Assumes a register master that never raises read and write strobes together.
// Assumes clk_en low freezes every flop while sys_rst still acts.
// Assumes work_busy falls only once all queued work has finished.
// Assumes software keeps the quiescing order; hardware does not check it.
//
// How it works
// - Cleared run waits for work drain, then halts
// - Forced halt at 16 ms after run cleared
// - Halted reads zero while running, one after stop
// - Halted blocks frame packets, drops received packets
// - Host error sets flag, clears run
// - Host error with enable drives error output
// - Pending rise sets event flag and event interrupt status (status on OR rise only in VF mode)
// - Any port change rise sets port flag
// - Power-up reload port flag from OR
// - Write one clears flag, no transaction status
// - Status at offset 04h, resets to one
// - Virtual function mode flag mirrors pending OR
//
// The strobed register port was left to the implementer.
module hrs_core #(
    parameter int NUM_INTR = 4,
    parameter int NUM_PORTS = 4,
    parameter int HALT_TIMEOUT_CYCLES = hrs_pkg::HALT_LIMIT_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire hrs_pkg::hrs_bus_req_s bus_req,
    output logic [hrs_pkg::DATA_W-1:0] bus_rdata,
    input wire logic work_busy,
    input wire logic internal_error,
    input wire logic host_access_error,
    input wire logic [NUM_INTR-1:0] interrupter_pending,
    input wire logic [NUM_PORTS-1:0] port_change_bits,
    input wire logic power_d3_to_d0,
    input wire logic vf_mode,
    output logic exec_enable,
    output logic work_abort,
    output logic frame_tx_enable,
    output logic packet_rx_accept,
    output logic host_error_signal,
    output logic irq
);
    import hrs_pkg::*;

    // ************************************************************
    // Halt timer
    // ************************************************************
    localparam int TMR_W = $clog2(HALT_TIMEOUT_CYCLES + 1);
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(HALT_TIMEOUT_CYCLES - 1);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        hrs_state_e state;
        logic run_stop;
        logic serr_enable;
        logic halted_flag;
        logic host_system_error_flag;
        logic event_irq_flag;
        logic port_change_flag;
        logic [TMR_W-1:0] tmr;
        logic [NUM_INTR-1:0] pend_prev;
        logic pend_or_prev;
        logic [NUM_PORTS-1:0] pchg_prev;
        logic [IRQ_W-1:0] irq_sts;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic sys_err;
        logic exec_en;
        logic abort;
        logic tx_en;
        logic rx_acc;
        logic [DATA_W-1:0] rdata;
    } hrs_regs_s;

    hrs_regs_s st_reg;
    hrs_regs_s st_next;

    // ************************************************************
    // Decode and event strobes
    // ************************************************************
    logic wr_cmd;
    logic wr_sts;
    logic wr_mask;
    logic rd_irq;
    logic err_evt;
    logic pend_evt;
    logic pend_or;
    logic port_evt;
    logic halt_evt;
    logic drain_done;
    logic [IRQ_W-1:0] irq_evt;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        st_next = st_reg;

        // ************************************************************
        // Bus decode and edge detect
        // ************************************************************
        wr_cmd = bus_req.wr && (bus_req.addr == OFF_RUN_CONTROL);
        wr_sts = bus_req.wr && (bus_req.addr == OFF_CONTROLLER_STATUS);
        wr_mask = bus_req.wr && (bus_req.addr == OFF_IRQ_MASK);
        rd_irq = bus_req.rd && (bus_req.addr == OFF_IRQ_STATUS);
        err_evt = internal_error || host_access_error;
        pend_or = |interrupter_pending;
        pend_evt = |(interrupter_pending & ~st_reg.pend_prev);
        port_evt = |(port_change_bits & ~st_reg.pchg_prev);
        halt_evt = 1'b0;
        drain_done = 1'b0;

        // ************************************************************
        // Command register
        // ************************************************************
        if (wr_cmd)
        begin
            st_next.run_stop = bus_req.wdata[RUN_STOP_BIT];
            st_next.serr_enable = bus_req.wdata[SERR_ENABLE_BIT];
        end
        if (err_evt)
        begin
            st_next.run_stop = 1'b0;
        end

        // ************************************************************
        // Host system error flag, set wins over clear
        // ************************************************************
        if (wr_sts && bus_req.wdata[HOST_ERR_BIT])
        begin
            st_next.host_system_error_flag = 1'b0;
        end
        if (err_evt)
        begin
            st_next.host_system_error_flag = 1'b1;
        end

        // ************************************************************
        // Event flag
        // ************************************************************
        if (vf_mode)
        begin
            st_next.event_irq_flag = pend_or;
        end
        else
        begin
            if (wr_sts && bus_req.wdata[EVENT_IRQ_BIT])
            begin
                st_next.event_irq_flag = 1'b0;
            end
            if (pend_evt)
            begin
                st_next.event_irq_flag = 1'b1;
            end
        end
        st_next.pend_prev = interrupter_pending;
        st_next.pend_or_prev = pend_or;

        // ************************************************************
        // Port change flag
        // ************************************************************
        if (wr_sts && bus_req.wdata[PORT_CHANGE_BIT])
        begin
            st_next.port_change_flag = 1'b0;
        end
        if (power_d3_to_d0)
        begin
            st_next.port_change_flag = |port_change_bits;
        end
        if (port_evt)
        begin
            st_next.port_change_flag = 1'b1;
        end
        st_next.pchg_prev = port_change_bits;

        // ************************************************************
        // Halt sequencer
        // ************************************************************
        st_next.abort = 1'b0;
        case (st_reg.state)
            HRS_RUNNING:
            begin
                if (!st_next.run_stop)
                begin
                    st_next.state = HRS_DRAINING;
                    st_next.tmr = '0;
                end
            end
            HRS_DRAINING:
            begin
                if (st_next.run_stop)
                begin
                    st_next.state = HRS_RUNNING;
                end
                else if (!work_busy)
                begin
                    drain_done = 1'b1;
                end
                else if (st_reg.tmr >= TMR_LAST)
                begin
                    drain_done = 1'b1;
                    st_next.abort = 1'b1;
                end
                else
                begin
                    st_next.tmr = st_reg.tmr + 1'b1;
                end
                if (drain_done)
                begin
                    st_next.state = HRS_HALTED;
                    halt_evt = 1'b1;
                end
            end
            HRS_HALTED:
            begin
                if (st_next.run_stop)
                begin
                    st_next.state = HRS_RUNNING;
                end
            end
            default:
            begin
                st_next.state = HRS_HALTED;
                st_next.run_stop = 1'b0;
            end
        endcase
        st_next.halted_flag = (st_next.state == HRS_HALTED);
        st_next.exec_en = !st_next.halted_flag;
        st_next.tx_en = !st_next.halted_flag;
        st_next.rx_acc = !st_next.halted_flag;
        st_next.sys_err = st_next.host_system_error_flag && st_next.serr_enable;

        // ************************************************************
        // Interrupt status, mask and output
        // ************************************************************
        irq_evt = '0;
        irq_evt[IRQ_HALT_BIT] = halt_evt;
        irq_evt[IRQ_HOST_ERR_BIT] = err_evt;
        irq_evt[IRQ_EVENT_BIT] = vf_mode ? (pend_or && !st_reg.pend_or_prev) : pend_evt;
        irq_evt[IRQ_PORT_BIT] = port_evt;
        if (rd_irq)
        begin
            st_next.irq_sts = '0;
        end
        st_next.irq_sts = st_next.irq_sts | irq_evt;
        if (wr_mask)
        begin
            st_next.irq_mask = bus_req.wdata[IRQ_W-1:0];
        end
        st_next.irq = |(st_next.irq_sts & st_next.irq_mask);

        // ************************************************************
        // Read data, one cycle after the strobe
        // ************************************************************
        st_next.rdata = '0;
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                OFF_RUN_CONTROL:
                begin
                    st_next.rdata[RUN_STOP_BIT] = st_reg.run_stop;
                    st_next.rdata[SERR_ENABLE_BIT] = st_reg.serr_enable;
                end
                OFF_CONTROLLER_STATUS:
                begin
                    st_next.rdata[HALTED_BIT] = st_reg.halted_flag;
                    st_next.rdata[HOST_ERR_BIT] = st_reg.host_system_error_flag;
                    st_next.rdata[EVENT_IRQ_BIT] = st_reg.event_irq_flag;
                    st_next.rdata[PORT_CHANGE_BIT] = st_reg.port_change_flag;
                end
                OFF_IRQ_STATUS:
                begin
                    st_next.rdata[IRQ_W-1:0] = st_reg.irq_sts;
                end
                OFF_IRQ_MASK:
                begin
                    st_next.rdata[IRQ_W-1:0] = st_reg.irq_mask;
                end
                default:
                begin
                    st_next.rdata = '0;
                end
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_reg.state <= HRS_HALTED;
            st_reg.run_stop <= 1'b0;
            st_reg.serr_enable <= 1'b0;
            st_reg.halted_flag <= CONTROLLER_STATUS_RESET[HALTED_BIT];
            st_reg.host_system_error_flag <= CONTROLLER_STATUS_RESET[HOST_ERR_BIT];
            st_reg.event_irq_flag <= CONTROLLER_STATUS_RESET[EVENT_IRQ_BIT];
            st_reg.port_change_flag <= CONTROLLER_STATUS_RESET[PORT_CHANGE_BIT];
            st_reg.tmr <= '0;
            st_reg.pend_prev <= '0;
            st_reg.pend_or_prev <= 1'b0;
            st_reg.pchg_prev <= '0;
            st_reg.irq_sts <= '0;
            st_reg.irq_mask <= IRQ_MASK_RESET;
            st_reg.irq <= 1'b0;
            st_reg.sys_err <= 1'b0;
            st_reg.exec_en <= 1'b0;
            st_reg.abort <= 1'b0;
            st_reg.tx_en <= 1'b0;
            st_reg.rx_acc <= 1'b0;
            st_reg.rdata <= '0;
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign bus_rdata = st_reg.rdata;
    assign exec_enable = st_reg.exec_en;
    assign work_abort = st_reg.abort;
    assign frame_tx_enable = st_reg.tx_en;
    assign packet_rx_accept = st_reg.rx_acc;
    assign host_error_signal = st_reg.sys_err;
    assign irq = st_reg.irq;

endmodule // hrs_core

// ==== testbench/hrs_core_asserts.sv ====
// Port checker for the run/stop and status block.
// Assumes one clock domain; attached to hrs_core by bind.
module hrs_core_asserts #(
    parameter int NUM_INTR = 4,
    parameter int NUM_PORTS = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire hrs_pkg::hrs_bus_req_s bus_req,
    input wire logic [hrs_pkg::DATA_W-1:0] bus_rdata,
    input wire logic work_busy,
    input wire logic internal_error,
    input wire logic host_access_error,
    input wire logic [NUM_INTR-1:0] interrupter_pending,
    input wire logic [NUM_PORTS-1:0] port_change_bits,
    input wire logic power_d3_to_d0,
    input wire logic vf_mode,
    input wire logic exec_enable,
    input wire logic work_abort,
    input wire logic frame_tx_enable,
    input wire logic packet_rx_accept,
    input wire logic host_error_signal,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import hrs_pkg::*;
    // ************************************************************
    // Properties
    // ************************************************************
    logic rd_st;
    assign rd_st = bus_req.rd && (bus_req.addr == OFF_CONTROLLER_STATUS);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst || !clk_en);
    sequence ev_rise_s;
        |(interrupter_pending & ~$past(interrupter_pending));
    endsequence
    sequence err_s;
        internal_error || host_access_error;
    endsequence
    tx_rx_gate_a: assert property (frame_tx_enable == exec_enable
        && packet_rx_accept == exec_enable) else $error("packet gates differ from run state");
    abort_pulse_a: assert property (work_abort |-> !exec_enable
        && $past(exec_enable) && $past(work_busy)) else $error("abort without forced halt");
    error_halt_a: assert property ((internal_error && exec_enable) ##1 !work_busy [*2]
        |-> ##[0:1] !exec_enable) else $error("no halt after error");
    halt_read_a: assert property (rd_st |=> bus_rdata[HALTED_BIT] == !$past(exec_enable))
        else $error("halted flag disagrees with run state");
    reserved_zero_a: assert property (rd_st |=> bus_rdata[1] == 1'b0
        && bus_rdata[7:5] == 3'h0) else $error("reserved status bit set");
    event_set_a: assert property (ev_rise_s ##1 rd_st |=> bus_rdata[EVENT_IRQ_BIT])
        else $error("event flag not set");
    port_set_a: assert property (|(port_change_bits & ~$past(port_change_bits)) ##1 rd_st
        |=> bus_rdata[PORT_CHANGE_BIT]) else $error("port flag not set");
    error_set_a: assert property (err_s ##1 rd_st |=> bus_rdata[HOST_ERR_BIT])
        else $error("host error flag not set");
    error_out_a: assert property (host_error_signal && rd_st |=> bus_rdata[HOST_ERR_BIT])
        else $error("error output without flag");
    rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
        else $error("read data outside read cycle");
endmodule // hrs_core_asserts

bind hrs_core hrs_core_asserts #(.NUM_INTR(NUM_INTR), .NUM_PORTS(NUM_PORTS)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .work_busy(work_busy), .internal_error(internal_error), .host_access_error(host_access_error),
    .interrupter_pending(interrupter_pending), .port_change_bits(port_change_bits),
    .power_d3_to_d0(power_d3_to_d0), .vf_mode(vf_mode), .exec_enable(exec_enable),
    .work_abort(work_abort), .frame_tx_enable(frame_tx_enable),
    .packet_rx_accept(packet_rx_accept), .host_error_signal(host_error_signal), .irq(irq));

// ==== testbench/hrs_engine_model.sv ====
// Behavioural execution engine: queued work that drains while enabled.
// Assumes software quiesced rings before stopping, so work is finite.
module hrs_engine_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic exec_enable,
    input wire logic load,
    input wire logic [15:0] work_len,
    output logic work_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Work counter
    // ************************************************************
    logic [15:0] left_reg;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            left_reg <= 16'h0;
        else if (load)
            left_reg <= work_len;
        else if (exec_enable && (left_reg != 16'h0))
            left_reg <= left_reg - 16'h1;
    end
    assign work_busy = (left_reg != 16'h0);
endmodule // hrs_engine_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the run/stop and status block.
// Assumes the engine model drives work_busy; the bench drives the rest.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import hrs_pkg::*;
    // ************************************************************
    // Signals, rows and instances
    // ************************************************************
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } hrs_row_s;
    localparam hrs_row_s ROWS [10] = '{'{1'b0, 8'h04, 32'h0, 32'h1},
        '{1'b0, 8'h14, 32'h0, 32'h0}, '{1'b1, 8'h14, 32'hF, 32'h0}, '{1'b0, 8'h14, 32'h0, 32'hF},
        '{1'b1, 8'h08, 32'hFFFF_FFFF, 32'h0}, '{1'b0, 8'h08, 32'h0, 32'h0},
        '{1'b1, 8'h04, 32'hFFFF_FFFF, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h1},
        '{1'b1, 8'h00, 32'h9, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h0}};
    logic clk = 0, sys_rst = 1, pwr = 0, vf = 0, ierr = 0, herr = 0, load = 0, clk_en = 1;
    hrs_bus_req_s req = '0;
    logic [3:0] pend = 4'h0, ports = 4'h0;
    logic [15:0] len = 16'h0;
    logic [31:0] rdata, q;
    logic busy, exec_en, abort, tx, rx, err_sig, irq, ab;
    int fails = 0, check_count = 0, n;
    always #5 clk = ~clk;
    hrs_core #(.HALT_TIMEOUT_CYCLES(20)) u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .bus_req(req), .bus_rdata(rdata), .work_busy(busy), .internal_error(ierr),
        .host_access_error(herr), .interrupter_pending(pend), .port_change_bits(ports),
        .power_d3_to_d0(pwr), .vf_mode(vf), .exec_enable(exec_en), .work_abort(abort),
        .frame_tx_enable(tx), .packet_rx_accept(rx), .host_error_signal(err_sig), .irq(irq));
    hrs_engine_model u_eng (.clk(clk), .sys_rst(sys_rst), .exec_enable(exec_en),
        .load(load), .work_len(len), .work_busy(busy));
    // ************************************************************
    // Tasks
    // ************************************************************
    task report_and_stop;
        $display("checks=%0d fails=%0d", check_count, fails);
        if ((fails == 0) && (check_count > 0))
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= w;
        req.rd <= !w;
        @(posedge clk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        #1 r = rdata;
        @(posedge clk);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task wait_halt(output int k);
        k = 0;
        ab = 0;
        #1;
        while (exec_en !== 1'b0)
        begin
            if (k == 100)
            begin
                fails++;
                report_and_stop;
            end
            @(posedge clk);
            #1 k++;
            ab = ab | abort;
        end
        @(posedge clk);
    endtask
    // ************************************************************
    // Sequence
    // ************************************************************
    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        foreach (ROWS[i])
        begin
            bus(ROWS[i].w, ROWS[i].a, ROWS[i].d, q);
            if (!ROWS[i].w)
                chk(q, ROWS[i].e);
        end
        pend <= 4'h1;
        @(posedge clk);
        rchk(8'h04, 32'h8);
        #1 chk(irq, 1'b1);
        @(posedge clk);
        rchk(8'h10, 32'h4);
        #1 chk(irq, 1'b0);
        @(posedge clk);
        bus(1'b1, 8'h04, 32'h0, q);
        rchk(8'h04, 32'h8);
        bus(1'b1, 8'h04, 32'h8, q);
        rchk(8'h04, 32'h0);
        pend <= 4'h0;
        vf <= 1'b1;
        @(posedge clk);
        pend <= 4'h2;
        repeat (2) @(posedge clk);
        bus(1'b1, 8'h04, 32'h8, q);
        rchk(8'h04, 32'h8);
        pend <= 4'h0;
        repeat (2) @(posedge clk);
        rchk(8'h04, 32'h0);
        vf <= 1'b0;
        ports <= 4'h2;
        @(posedge clk);
        rchk(8'h04, 32'h10);
        bus(1'b1, 8'h04, 32'h10, q);
        rchk(8'h04, 32'h0);
        pwr <= 1'b1;
        @(posedge clk);
        pwr <= 1'b0;
        rchk(8'h04, 32'h10);
        bus(1'b1, 8'h04, 32'h10, q);
        ports <= 4'h0;
        load <= 1'b1;
        len <= 16'h000F;
        @(posedge clk);
        load <= 1'b0;
        bus(1'b1, 8'h00, 32'h8, q);
        wait_halt(n);
        chk((n > 10) && (n < 20), 1'b1);
        chk(ab, 1'b0);
        chk(busy, 1'b0);
        #1 chk({tx, rx}, 2'b00);
        @(posedge clk);
        rchk(8'h04, 32'h1);
        bus(1'b0, 8'h10, 32'h0, q);
        chk(q & 32'h1, 32'h1);
        bus(1'b1, 8'h00, 32'h9, q);
        load <= 1'b1;
        len <= 16'h03E8;
        @(posedge clk);
        load <= 1'b0;
        bus(1'b1, 8'h00, 32'h8, q);
        wait_halt(n);
        chk((n >= 17) && (n <= 20), 1'b1);
        chk(ab, 1'b1);
        load <= 1'b1;
        len <= 16'h0;
        @(posedge clk);
        load <= 1'b0;
        bus(1'b1, 8'h00, 32'h9, q);
        ierr <= 1'b1;
        @(posedge clk);
        ierr <= 1'b0;
        bus(1'b0, 8'h04, 32'h0, q);
        chk(q & 32'h4, 32'h4);
        wait_halt(n);
        #1 chk(err_sig, 1'b1);
        @(posedge clk);
        rchk(8'h04, 32'h5);
        rchk(8'h00, 32'h8);
        bus(1'b1, 8'h04, 32'h4, q);
        #1 chk(err_sig, 1'b0);
        @(posedge clk);
        bus(1'b1, 8'h00, 32'h1, q);
        herr <= 1'b1;
        @(posedge clk);
        herr <= 1'b0;
        wait_halt(n);
        #1 chk(err_sig, 1'b0);
        @(posedge clk);
        rchk(8'h04, 32'h5);
        clk_en <= 1'b0;
        bus(1'b1, 8'h00, 32'h1, q);
        clk_en <= 1'b1;
        rchk(8'h04, 32'h5);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rchk(8'h04, 32'h1);
        report_and_stop;
    end
endmodule // tb_top
